//--- rtl/glpe_params.svh
// Constants for the GPIO level PWM encoder: register indices, field
// positions, reset values, time-base divisors and bus response codes.
// Assumes inclusion by bare name from the rtl/ folder.
`ifndef GLPE_PARAMS_SVH
`define GLPE_PARAMS_SVH

// Register indices; the byte address is four times the index.
`define GLPE_IDX_P1_LO 8'h60
`define GLPE_IDX_P1_HI 8'h52
`define GLPE_IDX_P2_LO 8'h53
`define GLPE_IDX_P2_HI 8'h54
`define GLPE_IDX_STATUS 8'h61

// Field positions inside a 16-bit configuration word.
`define GLPE_TB_MSB 15
`define GLPE_TB_LSB 14
`define GLPE_HC_MSB 13
`define GLPE_HC_LSB 7
`define GLPE_LC_MSB 6
`define GLPE_LC_LSB 0

// Reset values and writable masks.
`define GLPE_RST_HI_CFG 16'h3F80
`define GLPE_RST_LO_CFG 16'h007F
`define GLPE_MASK_HI_CFG 16'h3FFF
`define GLPE_MASK_LO_CFG 16'hFFFF

// Time base in master clock periods for select codes 0 to 3.
`define GLPE_DIV_TB0 11'h010
`define GLPE_DIV_TB1 11'h040
`define GLPE_DIV_TB2 11'h100
`define GLPE_DIV_TB3 11'h400

// Bus responses.
`define GLPE_RESP_OKAY 2'h0
`define GLPE_RESP_SLVERR 2'h2

`endif

//--- rtl/glpe_pkg.sv
// Types shared by the GPIO level PWM encoder modules.
// Assumes nothing of its surroundings.
package glpe_pkg;
  typedef logic [15:0] glpe_cfg_t;
  typedef logic [6:0] glpe_cnt_t;
  typedef logic [10:0] glpe_div_t;
  typedef logic [1:0] glpe_tb_t;
  typedef enum logic [2:0] {
    GLPE_ST_STATIC = 3'b001,
    GLPE_ST_HIGH = 3'b010,
    GLPE_ST_LOW = 3'b100
  } glpe_phase_e;
endpackage

//--- rtl/glpe_tick.sv
// Time-base prescaler: one tick every 16, 64, 256 or 1024 clocks.
// Assumes clr restarts the count so a period starts on a clean slot.
`timescale 1ns/10ps
`include "glpe_params.svh"
module glpe_tick (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input glpe_pkg::glpe_tb_t tb_sel,
  input wire logic clr,
  // Time base
  output glpe_pkg::glpe_div_t div,
  output logic tick
);
  import glpe_pkg::*;

  glpe_tb_t tb_reg;
  logic [9:0] pre_reg;
  logic [9:0] pre_next;

  // The select is taken only when the engine restarts a period, so a time base
  // written mid-period cannot stretch or cut the phase that is running.
  assign div = (tb_reg == 2'h0) ? `GLPE_DIV_TB0 :
               (tb_reg == 2'h1) ? `GLPE_DIV_TB1 :
               (tb_reg == 2'h2) ? `GLPE_DIV_TB2 : `GLPE_DIV_TB3;
  assign tick = ({1'b0, pre_reg} == (div - 11'h001));
  assign pre_next = (clr || tick) ? 10'h000 : (pre_reg + 10'h001);

  always_ff @(posedge clk) begin
    if (rst) begin
      pre_reg <= 10'h000;
      tb_reg <= 2'h0;
    end else begin
      pre_reg <= pre_next;
      if (clr) begin
        tb_reg <= tb_sel;
      end
    end
  end
endmodule // glpe_tick

//--- rtl/glpe_chan.sv
// One pin's PWM engine: picks the count pair of the commanded level,
// runs high then low phases in time-base ticks, or holds a static level.
// Assumes tick comes from glpe_tick, restarted by clr.
`timescale 1ns/10ps
`include "glpe_params.svh"
module glpe_chan (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration and level
  input wire logic level,
  input glpe_pkg::glpe_cfg_t hi_cfg,
  input glpe_pkg::glpe_cfg_t lo_cfg,
  // Time base
  input wire logic tick,
  input glpe_pkg::glpe_div_t div,
  output logic clr,
  // Waveform
  output logic pwm_reg
);
  import glpe_pkg::*;

  glpe_phase_e phase_reg;
  glpe_phase_e phase_next;
  glpe_cnt_t cur_hc_reg;
  glpe_cnt_t cur_lc_reg;
  glpe_cnt_t cnt_reg;
  glpe_cnt_t cnt_next;
  glpe_cnt_t sel_hc;
  glpe_cnt_t sel_lc;
  logic high_done;
  logic low_done;
  logic reload;
  logic sel_static;
  logic static_hi;
  logic pwm_next;
  logic [17:0] dur_reg;

  // The pair of the commanded level is only adopted at a period boundary.
  assign sel_hc = level ? hi_cfg[`GLPE_HC_MSB:`GLPE_HC_LSB]
                        : lo_cfg[`GLPE_HC_MSB:`GLPE_HC_LSB];
  assign sel_lc = level ? hi_cfg[`GLPE_LC_MSB:`GLPE_LC_LSB]
                        : lo_cfg[`GLPE_LC_MSB:`GLPE_LC_LSB];
  assign high_done = tick && (cnt_reg == (cur_hc_reg - 7'h01));
  assign low_done = tick && (cnt_reg == (cur_lc_reg - 7'h01));
  assign reload = (phase_reg == GLPE_ST_STATIC) ||
                  ((phase_reg == GLPE_ST_LOW) && low_done);
  assign sel_static = (sel_hc == 7'h00) || (sel_lc == 7'h00);
  assign static_hi = (sel_hc != 7'h00) && (sel_lc == 7'h00);
  assign clr = reload;
  assign cnt_next = (reload || ((phase_reg == GLPE_ST_HIGH) && high_done)) ? 7'h00 :
                    (tick ? (cnt_reg + 7'h01) : cnt_reg);
  assign pwm_next = (phase_next == GLPE_ST_HIGH) ||
                    ((phase_next == GLPE_ST_STATIC) && static_hi);

  always_comb begin
    case (phase_reg)
      GLPE_ST_STATIC: phase_next = sel_static ? GLPE_ST_STATIC : GLPE_ST_HIGH;
      GLPE_ST_HIGH: phase_next = high_done ? GLPE_ST_LOW : GLPE_ST_HIGH;
      GLPE_ST_LOW: begin
        if (!low_done) begin
          phase_next = GLPE_ST_LOW;
        end else begin
          phase_next = sel_static ? GLPE_ST_STATIC : GLPE_ST_HIGH;
        end
      end
      default: phase_next = GLPE_ST_STATIC;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_reg <= GLPE_ST_STATIC;
      cur_hc_reg <= 7'h00;
      cur_lc_reg <= 7'h00;
      cnt_reg <= 7'h00;
      pwm_reg <= 1'b0;
      dur_reg <= 18'h00001;
    end else begin
      phase_reg <= phase_next;
      cnt_reg <= cnt_next;
      pwm_reg <= pwm_next;
      dur_reg <= (phase_next != phase_reg) ? 18'h00001 : (dur_reg + 18'h00001);
      if (reload) begin
        cur_hc_reg <= sel_hc;
        cur_lc_reg <= sel_lc;
      end
    end
  end

  a_high_run_len: assert property (@(posedge clk) disable iff (rst)
    ((phase_reg == GLPE_ST_HIGH) && (phase_next == GLPE_ST_LOW)) |->
      (dur_reg == (18'(cur_hc_reg) * 18'(div)) && pwm_reg))
    else $error("high time differs from high count times time base");
  a_low_run_len: assert property (@(posedge clk) disable iff (rst)
    ((phase_reg == GLPE_ST_LOW) && (phase_next != GLPE_ST_LOW)) |->
      (dur_reg == (18'(cur_lc_reg) * 18'(div)) && !pwm_reg))
    else $error("low time differs from low count times time base");
  a_static_low_out: assert property (@(posedge clk) disable iff (rst)
    (reload && (sel_hc == 7'h00)) |=> (!pwm_reg && (phase_reg == GLPE_ST_STATIC)))
    else $error("zero high count did not give static low");
  a_static_high_out: assert property (@(posedge clk) disable iff (rst)
    (reload && (sel_hc != 7'h00) && (sel_lc == 7'h00)) |=>
      (pwm_reg && (phase_reg == GLPE_ST_STATIC)))
    else $error("zero low count did not give static high");
  a_reload_pair: assert property (@(posedge clk) disable iff (rst)
    reload |=> ((cur_hc_reg == $past(sel_hc)) && (cur_lc_reg == $past(sel_lc))))
    else $error("period did not adopt the pair of the commanded level");
endmodule // glpe_chan

//--- rtl/glpe_top.sv
// GPIO level PWM encoder for two pins, with an AXI4-Lite register slave.
// Assumes pin level inputs are synchronous to clk and one write and one
// read at most are outstanding on the bus.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/10ps
`include "glpe_params.svh"
module glpe_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Commanded pin levels
  input wire logic pin1_level,
  input wire logic pin2_level,
  // PWM outputs
  output logic pin1_pwm,
  output logic pin2_pwm
);
  import glpe_pkg::*;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  // Entry order: pin 1 low, pin 1 high, pin 2 low, pin 2 high.
  localparam int NCFG = 4;
  localparam logic [7:0] CFG_IDX [NCFG] = '{`GLPE_IDX_P1_LO, `GLPE_IDX_P1_HI,
                                            `GLPE_IDX_P2_LO, `GLPE_IDX_P2_HI};
  localparam glpe_cfg_t CFG_RST [NCFG] = '{`GLPE_RST_LO_CFG, `GLPE_RST_HI_CFG,
                                           `GLPE_RST_LO_CFG, `GLPE_RST_HI_CFG};
  localparam glpe_cfg_t CFG_MASK [NCFG] = '{`GLPE_MASK_LO_CFG, `GLPE_MASK_HI_CFG,
                                            `GLPE_MASK_LO_CFG, `GLPE_MASK_HI_CFG};

  glpe_cfg_t cfg_reg [NCFG];

  // ---------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------
  logic aw_full_reg;
  logic aw_full_next;
  logic w_full_reg;
  logic w_full_next;
  logic [11:0] waddr_reg;
  logic [15:0] wdata_reg;
  logic [1:0] wstrb_reg;
  logic aw_take;
  logic w_take;
  logic do_write;
  logic bvalid_next;
  logic [7:0] wr_idx;
  logic wr_aligned;
  logic [NCFG-1:0] wr_hit;
  logic wr_mapped;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  // Address and data may arrive in either order; the write lands once both are held.
  assign do_write = aw_full_reg && w_full_reg;
  assign aw_full_next = do_write ? 1'b0 : (aw_full_reg || aw_take);
  assign w_full_next = do_write ? 1'b0 : (w_full_reg || w_take);
  assign bvalid_next = do_write ? 1'b1 :
                       ((s_axi_bvalid && s_axi_bready) ? 1'b0 : s_axi_bvalid);
  assign wr_idx = waddr_reg[9:2];
  assign wr_aligned = (waddr_reg[1:0] == 2'h0) && (waddr_reg[11:10] == 2'h0);
  assign wr_mapped = wr_aligned && (|wr_hit);

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `GLPE_RESP_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      s_axi_awready <= !aw_full_next && !bvalid_next;
      s_axi_wready <= !w_full_next && !bvalid_next;
      s_axi_bvalid <= bvalid_next;
      if (do_write) begin
        s_axi_bresp <= wr_mapped ? `GLPE_RESP_OKAY : `GLPE_RESP_SLVERR;
      end
    end
  end

  // Payload registers carry no control meaning, so they skip the reset.
  always_ff @(posedge clk) begin
    if (aw_take) begin
      waddr_reg <= s_axi_awaddr;
    end
    if (w_take) begin
      wdata_reg <= s_axi_wdata[15:0];
      wstrb_reg <= s_axi_wstrb[1:0];
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  // Bits above 15 are not stored; lanes 2 and 3 are accepted and dropped.
  // Reserved bits of the logic-high configs are masked so they read zero.
  genvar gi;
  generate
    for (gi = 0; gi < NCFG; gi++) begin : gen_cfg
      glpe_cfg_t merged;
      assign wr_hit[gi] = wr_aligned && (wr_idx == CFG_IDX[gi]);
      assign merged = {wstrb_reg[1] ? wdata_reg[15:8] : cfg_reg[gi][15:8],
                       wstrb_reg[0] ? wdata_reg[7:0] : cfg_reg[gi][7:0]};
      always_ff @(posedge clk) begin
        if (rst) begin
          cfg_reg[gi] <= CFG_RST[gi];
        end else if (do_write && wr_hit[gi]) begin
          cfg_reg[gi] <= merged & CFG_MASK[gi];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  logic ar_take;
  logic rvalid_next;
  logic [7:0] rd_idx;
  logic rd_aligned;
  logic rd_status;
  logic rd_mapped;
  logic [NCFG-1:0] rd_hit;
  glpe_cfg_t rd_term [NCFG];
  glpe_cfg_t rd_cfg;
  logic [31:0] status_word;
  logic [31:0] rd_word;

  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign rvalid_next = ar_take ? 1'b1 :
                       ((s_axi_rvalid && s_axi_rready) ? 1'b0 : s_axi_rvalid);
  assign rd_idx = s_axi_araddr[9:2];
  assign rd_aligned = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr[11:10] == 2'h0);
  assign rd_status = rd_aligned && (rd_idx == `GLPE_IDX_STATUS);
  assign rd_mapped = rd_status || (|rd_hit);

  generate
    for (gi = 0; gi < NCFG; gi++) begin : gen_rd
      assign rd_hit[gi] = rd_aligned && (rd_idx == CFG_IDX[gi]);
      assign rd_term[gi] = rd_hit[gi] ? cfg_reg[gi] : 16'h0000;
    end
  endgenerate

  assign rd_cfg = rd_term[0] | rd_term[1] | rd_term[2] | rd_term[3];
  // Status shows the live waveforms and the levels they encode.
  assign status_word = {28'h0000000, pin2_level, pin1_level, pin2_pwm, pin1_pwm};
  assign rd_word = rd_status ? status_word : {16'h0000, rd_cfg};

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `GLPE_RESP_OKAY;
    end else begin
      s_axi_arready <= !rvalid_next;
      s_axi_rvalid <= rvalid_next;
      if (ar_take) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_mapped ? `GLPE_RESP_OKAY : `GLPE_RESP_SLVERR;
      end
    end
  end

  // ---------------------------------------------------------------
  // PWM engines
  // ---------------------------------------------------------------
  // The time base of each pin lives in that pin's logic-low config.
  logic [1:0] level_w;
  logic [1:0] pwm_w;
  glpe_div_t div_w [2];

  assign level_w = {pin2_level, pin1_level};
  assign pin1_pwm = pwm_w[0];
  assign pin2_pwm = pwm_w[1];

  generate
    for (gi = 0; gi < 2; gi++) begin : gen_pin
      logic tick;
      logic clr;
      glpe_tick u_tick (
        .clk(clk),
        .rst(rst),
        .tb_sel(cfg_reg[2*gi][`GLPE_TB_MSB:`GLPE_TB_LSB]),
        .clr(clr),
        .div(div_w[gi]),
        .tick(tick)
      );
      glpe_chan u_chan (
        .clk(clk),
        .rst(rst),
        .level(level_w[gi]),
        .hi_cfg(cfg_reg[2*gi+1]),
        .lo_cfg(cfg_reg[2*gi]),
        .tick(tick),
        .div(div_w[gi]),
        .clr(clr),
        .pwm_reg(pwm_w[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_both_taken;
    aw_take && w_take;
  endsequence

  sequence s_resp_up;
    s_axi_bvalid && !s_axi_awready && !s_axi_wready;
  endsequence

  a_write_resp_time: assert property (@(posedge clk) disable iff (rst)
    s_both_taken |-> ##2 s_resp_up)
    else $error("write response not two cycles after address and data");
  a_read_resp_time: assert property (@(posedge clk) disable iff (rst)
    ar_take |=> (s_axi_rvalid && !s_axi_arready))
    else $error("read data not one cycle after address");
  a_p1hi_reset_val: assert property (@(posedge clk)
    $fell(rst) |-> (cfg_reg[1] == `GLPE_RST_HI_CFG))
    else $error("pin 1 logic-high config has wrong reset value");
  a_p2lo_reset_val: assert property (@(posedge clk)
    $fell(rst) |-> (cfg_reg[2] == `GLPE_RST_LO_CFG))
    else $error("pin 2 logic-low config has wrong reset value");
  a_reserved_reads_zero: assert property (@(posedge clk) disable iff (rst)
    (ar_take && rd_hit[1]) |=> (s_axi_rdata[31:14] == 18'h00000))
    else $error("reserved bits of pin 1 logic-high config read nonzero");
  a_write_lands_full: assert property (@(posedge clk) disable iff (rst)
    (do_write && wr_hit[2] && (wstrb_reg == 2'h3)) |=> (cfg_reg[2] == $past(wdata_reg)))
    else $error("full write to pin 2 logic-low config did not land");
  a_time_base_decode: assert property (@(posedge clk) disable iff (rst)
    (gen_pin[0].clr && (cfg_reg[0][`GLPE_TB_MSB:`GLPE_TB_LSB] == 2'h2)) |=>
      (div_w[0] == `GLPE_DIV_TB2))
    else $error("time base select 2 did not give 256 clocks");
  a_unmapped_error: assert property (@(posedge clk) disable iff (rst)
    (ar_take && !rd_mapped) |=> ((s_axi_rresp == `GLPE_RESP_SLVERR) &&
      (s_axi_rdata == 32'h00000000)))
    else $error("unmapped read not answered with slave error");
endmodule // glpe_top

//--- tb/tb_glpe_top.sv
// Self-checking bench for the two-pin level PWM encoder.
// Assumes glpe_top alone; the bench is the only AXI4-Lite master and drives the pin levels.
`timescale 1ns/10ps
module tb_glpe_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = 12'h000;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic pin1_level = 1'b0;
  logic pin2_level = 1'b0;
  logic pin1_pwm;
  logic pin2_pwm;
  logic mon_pin = 1'b0;
  wire pwm_mon = mon_pin ? pin2_pwm : pin1_pwm;
  int fail_count = 0;
  int checked = 0;
  int hc_tab [4] = '{3, 2, 1, 1};
  int lc_tab [4] = '{5, 1, 3, 1};

  always #20 clk = ~clk;

  glpe_top glpe_top_i (
    .clk(clk), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pin1_level(pin1_level), .pin2_level(pin2_level),
    .pin1_pwm(pin1_pwm), .pin2_pwm(pin2_pwm)
  );

  // ----------------------------------------------------------------
  // Compare and verdict tasks
  // ----------------------------------------------------------------
  task automatic report(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    report(got, exp);
  endtask

  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    report({30'h0, got}, {30'h0, exp});
  endtask

  task automatic cmp_time(input logic [31:0] got, input logic [31:0] exp);
    report(got, exp);
  endtask

  task automatic print_verdict();
    if (fail_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  // Both halves are offered together and each is dropped at the edge that takes it.
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_done;
    logic w_done;
    int n;
    aw_done = 1'b0;
    w_done = 1'b0;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_done && w_done) && n < 200) begin
      @(posedge clk);
      n++;
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    if (!(aw_done && w_done)) fail_count++;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    if (s_axi_bvalid !== 1'b1) fail_count++;
    s_axi_bready <= 1'b0;
    cmp_resp(s_axi_bresp, er);
  endtask

  task automatic axi_read(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (s_axi_arready !== 1'b1 && n < 200);
    if (s_axi_arready !== 1'b1) fail_count++;
    s_axi_arvalid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    if (s_axi_rvalid !== 1'b1) fail_count++;
    s_axi_rready <= 1'b0;
    cmp_word(s_axi_rdata, ed);
    cmp_resp(s_axi_rresp, er);
  endtask

  // ----------------------------------------------------------------
  // Waveform tasks
  // ----------------------------------------------------------------
  // A period is timed from a rising edge, so a half-finished old period is never measured.
  task automatic measure(input logic [31:0] hi_exp, input logic [31:0] lo_exp);
    logic [31:0] hi_n;
    logic [31:0] lo_n;
    int n;
    hi_n = 0;
    lo_n = 0;
    n = 0;
    while (pwm_mon !== 1'b0 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    while (pwm_mon !== 1'b1 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    while (pwm_mon === 1'b1 && hi_n < 9000) begin
      @(posedge clk);
      hi_n++;
    end
    while (pwm_mon === 1'b0 && lo_n < 9000) begin
      @(posedge clk);
      lo_n++;
    end
    cmp_time(hi_n, hi_exp);
    cmp_time(lo_n, lo_exp);
  endtask

  // The settle wait covers the longest period left running before a static pair applies.
  task automatic hold_check(input logic exp);
    logic [31:0] same;
    same = 0;
    repeat (300) @(posedge clk);
    repeat (64) begin
      @(posedge clk);
      if (pwm_mon === exp) same++;
    end
    cmp_time(same, 32'd64);
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    print_verdict();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    axi_read(12'h148, 32'h00003F80, 2'h0);
    axi_read(12'h14C, 32'h0000007F, 2'h0);
    axi_read(12'h180, 32'h0000007F, 2'h0);
    axi_read(12'h150, 32'h00003F80, 2'h0);
    axi_read(12'h000, 32'h00000000, 2'h2);
    axi_write(12'h3FC, 32'h00001234, 2'h2);
    hold_check(1'b0);
    pin1_level <= 1'b1;
    hold_check(1'b1);
    axi_write(12'h148, 32'h0000FFFF, 2'h0);
    axi_read(12'h148, 32'h00003FFF, 2'h0);
    measure(32'd2032, 32'd2032);
    for (int i = 0; i < 4; i++) begin
      axi_write(12'h180, 32'(i) << 14, 2'h0);
      axi_write(12'h148, 32'((hc_tab[i] << 7) | lc_tab[i]), 2'h0);
      measure(32'(hc_tab[i] * (16 << (2 * i))), 32'(lc_tab[i] * (16 << (2 * i))));
    end
    // The level-low pair must take over, then the level-high pair must come back.
    axi_write(12'h180, 32'h00000101, 2'h0);
    pin1_level <= 1'b0;
    measure(32'd32, 32'd16);
    pin1_level <= 1'b1;
    measure(32'd16, 32'd16);
    axi_write(12'h148, 32'h00000005, 2'h0);
    hold_check(1'b0);
    axi_write(12'h148, 32'h00000280, 2'h0);
    hold_check(1'b1);
    axi_write(12'h148, 32'h00000000, 2'h0);
    hold_check(1'b0);
    mon_pin <= 1'b1;
    s_axi_wstrb <= 4'h2;
    axi_write(12'h14C, 32'h0000407F, 2'h0);
    s_axi_wstrb <= 4'hF;
    axi_read(12'h14C, 32'h0000407F, 2'h0);
    axi_write(12'h14C, 32'h00004083, 2'h0);
    axi_read(12'h14C, 32'h00004083, 2'h0);
    measure(32'd64, 32'd192);
    pin2_level <= 1'b1;
    axi_write(12'h150, 32'h0000C100, 2'h0);
    axi_read(12'h150, 32'h00000100, 2'h0);
    hold_check(1'b1);
    axi_read(12'h184, 32'h0000000E, 2'h0);
    axi_write(12'h184, 32'h00000000, 2'h2);
    print_verdict();
  end
endmodule // tb_glpe_top
